// *** verilog/rmc_regs.v ***
// Purpose: configuration register bank of a point-of-load regulator
// Assumes: control-loop inputs come from logic on clk; the bus front end
//          delivers decoded word commands on clk
// Notes:   analog loop, current sense and group bus protocol live elsewhere;
//          the ok delay counter is sized for the full 5000 ms span
//
// Functional notes
// - min on-time is 2*(value+1)/512 period
// - clamp applied only when bit 7 set
// - bit 5 picks setpoint a or b
// - bit 2 chooses open-drain or push-pull ok
// - bit 1 enables external temperature compensation
// - bit 0 picks external or internal fault sensor
// - rail id field 12:8, values 0 to 31
// - phase position code 0..7 means slot 1..8
// - phase count codes odd only, count=code+1
// - wait programmed ms before asserting ok output
// - programmed delay rounded to nearest millisecond
// - eight-bit ramp gain, smaller gives slower ramp
// - sharing selects low-bandwidth shared start-up ramp
// - normal bandwidth restored once ok asserted
// - sharing disables soft-off, fall time ignored
`include "rmc_map.vh"

module rmc_regs #(
    parameter CYC_PER_MS = `RMC_CYC_PER_MS
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        cmd_valid,
    input  wire        cmd_write,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] cmd_wdata,
    output reg  [15:0] cmd_rdata_q,
    output reg         cmd_ack_q,
    output reg         cmd_unsupported_q,
    input  wire [8:0]  duty_req,
    output reg  [8:0]  duty_cmd_q,
    input  wire [15:0] voltage_setpoint_a,
    input  wire [15:0] voltage_setpoint_b,
    output reg  [15:0] vout_target_q,
    input  wire        stage_enable,
    input  wire        low_side_req,
    output reg         low_side_drive_out_q,
    input  wire        output_above_ok_thr,
    output reg         output_ok_signal_o_q,
    output reg         output_ok_signal_oe_q,
    input  wire [11:0] temp_internal,
    input  wire [11:0] temp_external,
    output reg  [11:0] temp_fault_src_q,
    output reg         ext_temp_comp_en_q,
    output reg  [4:0]  rail_id_q,
    output reg  [3:0]  phase_position_q,
    output reg  [3:0]  phase_count_q,
    output reg         phase_count_bad_q,
    output reg  [7:0]  ramp_gain_q,
    output reg         shared_ramp_q,
    output reg         loop_low_bw_q,
    input  wire [15:0] turn_off_fall_time,
    output reg  [15:0] fall_time_eff_q,
    output reg         soft_off_allowed_q
);

    reg  [15:0] misc_q;
    reg  [15:0] group_q;
    reg  [15:0] okdly_q;
    reg  [7:0]  gain_q;
    reg  [31:0] ms_cyc_q;
    reg  [12:0] ok_ms_q;
    reg         ok_q;

    wire [12:0] dly_ms;
    wire [6:0]  min_on;
    wire [2:0]  phases;
    wire        sharing;
    wire        ms_tick;

    // linear-format ms value, rounded half up, clamped to the legal span
    function [12:0] rmc_lin_ms;
        input [15:0] v;
        reg [5:0]  sh;
        reg [31:0] mag;
        reg [31:0] r;
        begin
            mag = {22'h0, v[9:0]};
            sh  = 6'h00;
            r   = 32'h0;
            if (v[10])
                r = 32'h0;
            else if (!v[15])
                r = mag << v[14:11];
            else
            begin
                sh = {1'b0, ~v[15:11]} + 6'h01;
                r  = (mag + (32'h1 << (sh - 6'h01))) >> sh;
            end
            if (r > {19'h0, `RMC_OKDLY_MAX_MS})
                r = {19'h0, `RMC_OKDLY_MAX_MS};
            rmc_lin_ms = r[12:0];
        end
    endfunction

    // reads answer with the word; a write answers with zero
    function [15:0] rmc_rd_word;
        input        wr;
        input [15:0] val;
        begin
            rmc_rd_word = wr ? 16'h0000 : val;
        end
    endfunction

    // shared ramp lasts only until ok, so the loop regains bandwidth
    function rmc_ramp_mode;
        input share;
        input en;
        input ok;
        begin
            rmc_ramp_mode = share & en & ~ok;
        end
    endfunction

    // even phase codes are unused and report zero phases
    function [3:0] rmc_phase_cnt;
        input [2:0] code;
        begin
            if (code[0])
                rmc_phase_cnt = {1'b0, code} + 4'h1;
            else
                rmc_phase_cnt = 4'h0;
        end
    endfunction

    assign dly_ms  = rmc_lin_ms(okdly_q);
    // 2*(value+1) in 1/512ths of the period
    assign min_on  = {1'b0, misc_q[`RMC_MIN_DUTY_HI:`RMC_MIN_DUTY_LO], 1'b0}
                   + 7'h02;
    assign phases  = group_q[`RMC_PHASES_HI:`RMC_PHASES_LO];
    // a valid phase count means this rail shares current
    assign sharing = phases[0];
    // one tick per millisecond worth of clk cycles
    assign ms_tick = (ms_cyc_q == CYC_PER_MS - 1);

    // register writes and reads; unknown codes answer with a flag
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            misc_q            <= `RMC_RST_MISC;
            group_q           <= `RMC_RST_GROUP;
            okdly_q           <= `RMC_RST_OKDLY;
            gain_q            <= `RMC_RST_GAIN;
            cmd_rdata_q       <= 16'h0000;
            cmd_ack_q         <= 1'b0;
            cmd_unsupported_q <= 1'b0;
        end
        else
        begin
            cmd_ack_q         <= cmd_valid;
            cmd_unsupported_q <= 1'b0;
            cmd_rdata_q       <= 16'h0000;
            // one answer per command, one cycle after it is taken
            if (cmd_valid)
            begin
                case (cmd_code)
                    `RMC_CMD_MISC:
                    begin
                        if (cmd_write)
                            misc_q <= cmd_wdata;
                        cmd_rdata_q <= rmc_rd_word(cmd_write, misc_q);
                    end
                    `RMC_CMD_GROUP:
                    begin
                        if (cmd_write)
                            group_q <= cmd_wdata;
                        cmd_rdata_q <= rmc_rd_word(cmd_write, group_q);
                    end
                    `RMC_CMD_OKDLY:
                    begin
                        if (cmd_write)
                            okdly_q <= cmd_wdata;
                        cmd_rdata_q <= rmc_rd_word(cmd_write, okdly_q);
                    end
                    `RMC_CMD_GAIN:
                    begin
                        // byte register; any value accepted
                        if (cmd_write)
                            gain_q <= cmd_wdata[7:0];
                        cmd_rdata_q <= rmc_rd_word(cmd_write, {8'h00, gain_q});
                    end
                    default:
                        cmd_unsupported_q <= 1'b1;
                endcase
            end
        end
    end

    // ok delay timer: restarts whenever the output falls below threshold
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ms_cyc_q <= 32'h0;
            ok_ms_q  <= 13'h0000;
            ok_q     <= 1'b0;
        end
        else if (!output_above_ok_thr)
        begin
            ms_cyc_q <= 32'h0;
            ok_ms_q  <= 13'h0000;
            ok_q     <= 1'b0;
        end
        // counting stops once the delay is met, so neither counter wraps
        else if (ok_ms_q >= dly_ms)
            ok_q <= 1'b1;
        else
        begin
            ms_cyc_q <= ms_tick ? 32'h0 : ms_cyc_q + 32'h1;
            if (ms_tick)
                ok_ms_q <= ok_ms_q + 13'h0001;
        end
    end

    // loop datapath steering from the mode bits
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            duty_cmd_q           <= 9'h000;
            vout_target_q        <= 16'h0000;
            low_side_drive_out_q <= 1'b0;
            temp_fault_src_q     <= 12'h000;
            ext_temp_comp_en_q   <= 1'b0;
        end
        else
        begin
            // clamp only raises the on-time; a longer request passes
            if (misc_q[`RMC_MIN_DUTY_EN] && duty_req < {2'b00, min_on})
                duty_cmd_q <= {2'b00, min_on};
            else
                duty_cmd_q <= duty_req;
            vout_target_q <= misc_q[`RMC_VSET_SEL] ? voltage_setpoint_b
                                                   : voltage_setpoint_a;
            low_side_drive_out_q <= stage_enable ? low_side_req
                                                 : misc_q[`RMC_LOW_IDLE];
            temp_fault_src_q <= misc_q[`RMC_EXT_TEMP_FLT] ? temp_external
                                                          : temp_internal;
            ext_temp_comp_en_q <= misc_q[`RMC_EXT_TEMP_EN];
        end
    end

    // ok pin drive; reset leaves an open-drain pin pulling low
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            output_ok_signal_o_q  <= 1'b0;
            output_ok_signal_oe_q <= 1'b1;
        end
        else
        begin
            // open-drain only pulls low; push-pull drives both levels
            output_ok_signal_o_q  <= misc_q[`RMC_OK_PUSH_PULL] & ok_q;
            output_ok_signal_oe_q <= misc_q[`RMC_OK_PUSH_PULL] | ~ok_q;
        end
    end

    // group identity and current-sharing mode
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rail_id_q          <= 5'h00;
            phase_position_q   <= 4'h1;
            phase_count_q      <= 4'h0;
            phase_count_bad_q  <= 1'b1;
            ramp_gain_q        <= 8'h00;
            shared_ramp_q      <= 1'b0;
            loop_low_bw_q      <= 1'b0;
            fall_time_eff_q    <= 16'h0000;
            soft_off_allowed_q <= 1'b1;
        end
        else
        begin
            rail_id_q <= group_q[`RMC_RAIL_ID_HI:`RMC_RAIL_ID_LO];
            phase_position_q <= {1'b0, group_q[`RMC_PHASE_POS_HI:
                                               `RMC_PHASE_POS_LO]}
                              + 4'h1;
            phase_count_q     <= rmc_phase_cnt(phases);
            phase_count_bad_q <= ~phases[0];
            ramp_gain_q <= gain_q;
            shared_ramp_q <= rmc_ramp_mode(sharing, stage_enable,
                                           ok_q);
            loop_low_bw_q <= rmc_ramp_mode(sharing, stage_enable,
                                           ok_q);
            fall_time_eff_q <= sharing ? 16'h0000
                                       : turn_off_fall_time;
            soft_off_allowed_q <= ~sharing;
        end
    end

endmodule

// *** verilog/rmc_map.vh ***
// Purpose: constants of the regulator configuration register bank
// Assumes: command codes are the management bus command bytes
// Notes:   reset values are zero throughout
`ifndef RMC_MAP_VH
`define RMC_MAP_VH

`define RMC_CMD_MISC        8'hd1
`define RMC_CMD_GROUP       8'hd3
`define RMC_CMD_OKDLY       8'hd4
`define RMC_CMD_GAIN        8'hd5

`define RMC_RST_MISC        16'h0000
`define RMC_RST_GROUP       16'h0000
`define RMC_RST_OKDLY       16'h0000
`define RMC_RST_GAIN        8'h00

`define RMC_MIN_DUTY_HI     15
`define RMC_MIN_DUTY_LO     11
`define RMC_MIN_DUTY_EN     7
`define RMC_VSET_SEL        5
`define RMC_LOW_IDLE        3
`define RMC_OK_PUSH_PULL    2
`define RMC_EXT_TEMP_EN     1
`define RMC_EXT_TEMP_FLT    0

`define RMC_PHASE_POS_HI    15
`define RMC_PHASE_POS_LO    13
`define RMC_RAIL_ID_HI      12
`define RMC_RAIL_ID_LO      8
`define RMC_PHASES_HI       2
`define RMC_PHASES_LO       0

`define RMC_OKDLY_MAX_MS    13'd5000
`define RMC_MS_NS           1000000
`define RMC_CLK_NS          5
`define RMC_CYC_PER_MS      (`RMC_MS_NS / `RMC_CLK_NS)

`endif

// *** verif/rmc_host.sv ***
// Purpose: host model driving the word command port
// Assumes: one command in flight, answer one clock after it is taken
// Notes:   released write data shows the inverse of the last word
module rmc_host (
    input  wire         clk,
    output logic        cmd_valid,
    output logic        cmd_write,
    output logic [7:0]  cmd_code,
    output logic [15:0] cmd_wdata,
    input  wire         cmd_ack_q,
    input  wire  [15:0] cmd_rdata_q,
    input  wire         cmd_unsupported_q
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end
    task xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
              output logic [15:0] r, output logic [1:0] s);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_code  <= c;
        cmd_wdata <= d;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~d;
        #1;
        r = cmd_rdata_q;
        s = {cmd_ack_q, cmd_unsupported_q};
    endtask
endmodule

// *** verif/rmc_regs_sva.sv ***
// Purpose: port checks for the regulator register bank
// Assumes: shadow copies of the two mode registers track host writes
// Notes:   outputs lag their cause by one clock
`include "rmc_map.vh"
module rmc_chk (
    input wire        clk,
    input wire        rst,
    input wire        cmd_valid,
    input wire        cmd_write,
    input wire [7:0]  cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [8:0]  duty_req,
    input wire [8:0]  duty_cmd_q,
    input wire        stage_enable,
    input wire        low_side_drive_out_q,
    input wire        output_above_ok_thr,
    input wire        output_ok_signal_o_q,
    input wire        output_ok_signal_oe_q,
    input wire [4:0]  rail_id_q,
    input wire [3:0]  phase_position_q,
    input wire [3:0]  phase_count_q,
    input wire        loop_low_bw_q,
    input wire        soft_off_allowed_q,
    input wire [15:0] voltage_setpoint_a,
    input wire [15:0] voltage_setpoint_b,
    input wire [15:0] vout_target_q,
    input wire [11:0] temp_internal,
    input wire [11:0] temp_external,
    input wire [11:0] temp_fault_src_q,
    input wire        ext_temp_comp_en_q,
    input wire        phase_count_bad_q,
    input wire        shared_ramp_q,
    input wire [15:0] turn_off_fall_time,
    input wire [15:0] fall_time_eff_q
);
    timeunit 1ns;
    timeprecision 1ps;
    reg  [15:0] m_q;
    reg  [15:0] g_q;
    reg         live_q;
    wire [8:0]  mn = {3'b000, m_q[15:11], 1'b0} + 9'h002;
    // open-drain ok counts as asserted while released
    wire        ok_s = !output_ok_signal_oe_q | output_ok_signal_o_q;
    always @(posedge clk or posedge rst)
        if (rst)
        begin
            m_q    <= 16'h0000;
            g_q    <= 16'h0000;
            live_q <= 1'b0;
        end
        else
        begin
            live_q <= 1'b1;
            if (cmd_valid && cmd_write && cmd_code == `RMC_CMD_MISC)
                m_q <= cmd_wdata;
            if (cmd_valid && cmd_write && cmd_code == `RMC_CMD_GROUP)
                g_q <= cmd_wdata;
        end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_duty_clamp: assert property (
        live_q |-> duty_cmd_q == (($past(m_q[7]) && $past(duty_req) <
        $past(mn)) ? $past(mn) : $past(duty_req))) else $error("bad duty");
    a_low_idle: assert property (
        live_q && !$past(stage_enable) |->
        low_side_drive_out_q == $past(m_q[3])) else $error("bad idle");
    a_ok_mode: assert property (
        live_q |-> ($past(m_q[2]) ? output_ok_signal_oe_q
        : !output_ok_signal_o_q)) else $error("bad ok drive");
    a_ok_needs_thr: assert property (
        ok_s |-> $past(output_above_ok_thr, 2)) else $error("early ok");
    a_rail_phase: assert property (
        live_q |-> rail_id_q == $past(g_q[12:8]) && phase_position_q ==
        {1'b0, $past(g_q[15:13])} + 4'h1) else $error("bad rail id");
    a_phase_count: assert property (
        live_q |-> phase_count_q == ($past(g_q[0]) ?
        {1'b0, $past(g_q[2:0])} + 4'h1 : 4'h0) &&
        phase_count_bad_q == !$past(g_q[0])) else $error("bad count");
    a_soft_off: assert property (
        live_q |-> soft_off_allowed_q == !$past(g_q[0]))
        else $error("bad soft off");
    a_bw_restore: assert property (
        ok_s && $past(ok_s) |-> !loop_low_bw_q) else $error("low bw");
    a_vset_pick: assert property (
        live_q |-> vout_target_q == ($past(m_q[5]) ?
        $past(voltage_setpoint_b) : $past(voltage_setpoint_a)))
        else $error("bad setpoint");
    a_temp_sel: assert property (
        live_q |-> ext_temp_comp_en_q == $past(m_q[1]) &&
        temp_fault_src_q == ($past(m_q[0]) ? $past(temp_external)
        : $past(temp_internal))) else $error("bad temp select");
    a_ramp_mode: assert property (
        live_q |-> shared_ramp_q == ($past(g_q[0]) && $past(stage_enable)
        && !ok_s) && loop_low_bw_q == shared_ramp_q)
        else $error("bad ramp mode");
    a_fall_time: assert property (
        live_q |-> fall_time_eff_q == ($past(g_q[0]) ? 16'h0000
        : $past(turn_off_fall_time))) else $error("bad fall time");
    c_ok: cover property (ok_s);
    c_clamp: cover property (live_q && duty_cmd_q != $past(duty_req));
    c_eight: cover property (phase_count_q == 4'h8);
    c_bw_back: cover property (ok_s && $past(shared_ramp_q));
endmodule
bind rmc_regs rmc_chk chk_u (.*);

// *** verif/tb_top.sv ***
// Purpose: self-checking bench for the regulator register bank
// Assumes: short millisecond count, inputs randomised every clock
// Notes:   ok delay window allows the pipeline slack of the pin
`include "rmc_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MS = 10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic output_above_ok_thr = 1'b0;
    logic cmd_valid, cmd_write, cmd_ack_q, cmd_unsupported_q;
    logic [7:0] cmd_code, ramp_gain_q, c;
    logic [15:0] cmd_wdata, cmd_rdata_q, vout_target_q, rd, w;
    logic [15:0] voltage_setpoint_a, voltage_setpoint_b;
    logic [15:0] turn_off_fall_time, fall_time_eff_q;
    logic [8:0] duty_req, duty_cmd_q;
    logic stage_enable, low_side_req, low_side_drive_out_q;
    logic output_ok_signal_o_q, output_ok_signal_oe_q, ext_temp_comp_en_q;
    logic [11:0] temp_internal, temp_external, temp_fault_src_q;
    logic [4:0] rail_id_q;
    logic [3:0] phase_position_q, phase_count_q;
    logic phase_count_bad_q, shared_ramp_q, loop_low_bw_q;
    logic soft_off_allowed_q;
    logic [1:0] st;
    int num_errors = 0;
    int checks = 0;
    int n;
    logic [7:0] codes [5] = '{8'hd1, 8'hd3, 8'hd4, 8'hd5, 8'hd2};
    logic [15:0] dly [3] = '{16'h0002, 16'hf805, 16'hf009};
    int dms [3] = '{2, 3, 2};
    wire ok_s = !output_ok_signal_oe_q | output_ok_signal_o_q;
    rmc_regs #(.CYC_PER_MS(MS)) dut_u (.*);
    rmc_host host_u (.*);
    always #2.5 clk = ~clk;
    function automatic logic [15:0] exp_rd(logic [7:0] k, logic [15:0] d);
        if (k == `RMC_CMD_GAIN)
            return {8'h00, d[7:0]};
        return (k == 8'hd2) ? 16'h0000 : d;
    endfunction
    task rnd_in;
        duty_req <= 9'($urandom);
        voltage_setpoint_a <= 16'($urandom);
        voltage_setpoint_b <= 16'($urandom);
        stage_enable <= 1'($urandom);
        low_side_req <= 1'($urandom);
        temp_internal <= 12'($urandom);
        temp_external <= 12'($urandom);
        turn_off_fall_time <= 16'($urandom);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task summarize;
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        #50000;
        num_errors++;
        summarize;
    end
    initial
    begin
        void'($urandom(32'hcaa5));
        // the input thread is forked after seeding so it inherits the seed
        rnd_in;
        fork
            forever
            begin
                @(posedge clk);
                rnd_in;
            end
        join_none
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset contents, and the unknown code is refused
        foreach (codes[i])
        begin
            host_u.xfer(1'b0, codes[i], 16'h0000, rd, st);
            chk(rd, 16'h0000);
            chk(st, {1'b1, codes[i] == 8'hd2});
        end
        repeat (40)
        begin
            c = codes[$urandom_range(4, 0)];
            w = $urandom;
            if (c == `RMC_CMD_GAIN)
                w = $urandom_range(5, 1);
            host_u.xfer(1'b1, c, w, rd, st);
            host_u.xfer(1'b0, c, 16'h0000, rd, st);
            chk(rd, exp_rd(c, w));
            chk(st, {1'b1, c == 8'hd2});
            if (c == `RMC_CMD_GAIN)
                chk({8'h00, ramp_gain_q}, exp_rd(c, w));
        end
        // reset in mid-run returns the group register to its reset word and the phase position to slot 1
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host_u.xfer(1'b0, `RMC_CMD_GROUP, 16'h0000, rd, st);
        chk(rd, `RMC_RST_GROUP);
        chk(phase_position_q, 16'h0001);
        host_u.xfer(1'b1, `RMC_CMD_MISC, 16'hf880, rd, st);
        for (int k = 0; k < 8; k++)
        begin
            host_u.xfer(1'b1, `RMC_CMD_GROUP, 16'(k * 16'h2001), rd, st);
            repeat (2) @(posedge clk);
            #1;
            chk(phase_count_q, k[0] ? 16'(k + 1) : 16'h0000);
            chk(phase_position_q, 16'(k + 1));
        end
        // fractional delays must land on the nearest whole millisecond
        foreach (dly[i])
        begin
            host_u.xfer(1'b1, `RMC_CMD_OKDLY, dly[i], rd, st);
            @(posedge clk);
            output_above_ok_thr <= 1'b1;
            n = 0;
            while (!ok_s && n < 200)
            begin
                @(posedge clk);
                #1;
                n++;
            end
            chk(16'(n >= dms[i] * MS && n <= dms[i] * MS + 4), 1);
            @(posedge clk);
            output_above_ok_thr <= 1'b0;
            repeat (4) @(posedge clk);
        end
        summarize;
    end
endmodule
